// ---- core/ost_pkg.sv ----
// Purpose: Shared constants and types for the stabilization timer.
// Assumes: Register addresses are the CPU's 16-bit special-register space.
// Notes: Thresholds are powers of two of the crystal period.
package ost_pkg;

  // Register addresses and values after reset
  localparam logic [15:0] STATUS_ADDR = 16'hffa3;
  localparam logic [15:0] SELECT_ADDR = 16'hffa4;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [2:0] SELECT_RESET = 3'h5;

  // Field layout: five flags in the status low bits, select in bits 2..0
  localparam int unsigned FLAG_N = 5;
  localparam int unsigned SEL_W = 3;
  localparam int unsigned CNT_W = 17;

  // Wait selection codes
  localparam logic [2:0] SEL_2E11 = 3'h1;
  localparam logic [2:0] SEL_2E13 = 3'h2;
  localparam logic [2:0] SEL_2E14 = 3'h3;
  localparam logic [2:0] SEL_2E15 = 3'h4;
  localparam logic [2:0] SEL_2E16 = 3'h5;

  // Count bit for each threshold, shortest first
  localparam logic [4:0] THR_POS [FLAG_N] = '{5'h0b, 5'h0d, 5'h0e, 5'h0f,
                                               5'h10};

  // Crystal input passes three flip-flops
  localparam int unsigned SYNC_STAGES = 3;

  // Wake-up hold state
  typedef enum logic [0:0] {HOLD_IDLE, HOLD_WAIT} hold_state_t;

  // Selection code to threshold index; prohibited codes take the longest
  function automatic logic [2:0] sel_to_idx(input logic [2:0] sel);
    unique case (sel)
      SEL_2E11: sel_to_idx = 3'h0;
      SEL_2E13: sel_to_idx = 3'h1;
      SEL_2E14: sel_to_idx = 3'h2;
      SEL_2E15: sel_to_idx = 3'h3;
      default: sel_to_idx = 3'h4;
    endcase
  endfunction

endpackage

// ---- core/count_if.sv ----
// Purpose: Carries control and state between timer control and counter.
// Assumes: Single clock domain.
// Notes: limit_pos is the count bit at which counting stops.
interface count_if;
  logic clear;
  logic tick;
  logic [4:0] limit_pos;
  logic [ost_pkg::CNT_W-1:0] count;
  logic done;

  modport ctl (output clear, output tick, output limit_pos,
               input count, input done);
  modport cnt (input clear, input tick, input limit_pos,
               output count, output done);
endinterface

// ---- core/stab_counter.sv ----
// Purpose: Binary count of crystal periods, stopping at a set bit.
// Assumes: tick is a one-cycle pulse per crystal rising edge.
// Notes: Clear has priority over tick so a restart is exact.
module stab_counter (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // Control side
  count_if.cnt cif
);
  import ost_pkg::*;

  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;

  // Stop at the selected power of two, restart on clear
  assign cif.done = count_reg[cif.limit_pos];
  assign count_next = cif.clear ? '0 :
                      (cif.tick && !cif.done) ? count_reg + 1'b1 :
                      count_reg;
  assign cif.count = count_reg;

  // Counter register
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  property p_count_step;
    @(posedge mclk) disable iff (!resetn)
    cif.tick && !cif.done && !cif.clear |=>
      count_reg == $past(count_reg) + 1'b1;
  endproperty
  a_count_step: assert property (p_count_step)
    else $error("counter did not advance on a crystal edge");

endmodule

// ---- core/stabilization_timer.sv ----
// Purpose: Crystal oscillation stabilization timer with status and select.
// Assumes: Crystal pin is slow against mclk; resetn merges every reset
//   source; stop_exec and stop_release are one-cycle pulses from the CPU.
// Notes: Bit reads of status return the chosen bit; bit writes to select are dropped.
//
// Contract
// - Status register shows how far the crystal stabilization count advanced.
// - Status is read-only, readable by bit and by byte access.
// - Status clears on reset, stop instruction, and oscillator stop bit set; a new threshold in the same cycle still sets its flag and keeps lower flags.
// - Five flags in bits 4..0: 2^11 in bit 4 through 2^16 in bit 0.
// - Flags set in order from shortest threshold and stay set until cleared.
// - Counter halts at selected wait; higher flags never set afterwards.
// - On crystal CPU clock, hold execution after stop until wait elapses.
// - Select codes 1..5 give 2^11,2^13,2^14,2^15,2^16; others prohibited.
// - Select register is five after every reset.
// - Select register is written by byte access only.
// - Wait counts from real oscillation, excluding start-up delay.
// - Oscillator stops while the stop bit is one, runs while zero; the code also keeps it stopped from stop_exec until stop_release.
module stabilization_timer (
  // Clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // CPU register access
  input wire logic [15:0] reg_addr,
  input wire logic reg_rd,
  input wire logic reg_wr,
  input wire logic reg_bit_op,
  input wire logic [2:0] reg_bit_sel,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata_reg,
  output logic reg_rbit_reg,
  // Power and clock control
  input wire logic main_crystal,
  input wire logic main_osc_stop,
  input wire logic stop_exec,
  input wire logic stop_release,
  input wire logic cpu_on_crystal,
  output logic main_osc_enable_reg,
  output logic cpu_hold_reg
);
  import ost_pkg::*;

  count_if cif ();

  logic [SYNC_STAGES-1:0] sync_reg;
  logic level_reg;
  logic level_next;
  logic [SEL_W-1:0] sel_reg;
  logic [FLAG_N-1:0] flag_reg;
  logic [FLAG_N-1:0] flag_next;
  logic [FLAG_N-1:0] flag_set;
  logic any_set;
  logic stop_state_reg;
  hold_state_t hold_reg;
  hold_state_t hold_next;
  logic [7:0] status;
  logic [7:0] read_byte;
  logic clear_evt;
  logic hit_status;
  logic hit_select;
  logic sel_write;
  logic [2:0] limit_idx;

  // Crystal edge detect; edge counts once second and third stages agree
  assign level_next = (sync_reg[1] == sync_reg[2]) ? sync_reg[2] : level_reg;
  assign cif.tick = level_next && !level_reg;

  // Crystal input synchroniser and confirmed level
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sync_reg <= '0;
      level_reg <= 1'b0;
    end else begin
      sync_reg <= {sync_reg[SYNC_STAGES-2:0], main_crystal};
      level_reg <= level_next;
    end
  end

  // Clearing events restart count and flags; reset clears via resetn
  assign clear_evt = stop_exec || main_osc_stop;
  assign cif.clear = clear_evt;
  assign limit_idx = sel_to_idx(sel_reg);
  assign cif.limit_pos = THR_POS[limit_idx];

  // New threshold per flag; a count bit that merely stays high is no event
  generate
    for (genvar i = 0; i < FLAG_N; i++) begin : g_flag
      assign flag_set[i] = cif.count[THR_POS[i]] && !flag_reg[i];
      // A new threshold beats a coincident clear and keeps the lower flags,
      // so the status stays a thermometer and no threshold is lost
      assign flag_next[i] = flag_set[i] ? 1'b1 :
                            (any_set && flag_reg[i]) ? 1'b1 :
                            clear_evt ? 1'b0 : flag_reg[i];
    end
  endgenerate
  assign any_set = |flag_set;

  // Flags held sticky until the next clearing event
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // Status view: 2^11 flag on bit 4, 2^16 flag on bit 0
  assign status = {3'h0, flag_reg[0], flag_reg[1], flag_reg[2],
                   flag_reg[3], flag_reg[4]};

  // Register decode
  assign hit_status = (reg_addr == STATUS_ADDR);
  assign hit_select = (reg_addr == SELECT_ADDR);
  // Bit writes are not decoded, so bit set/clear cannot alter the wait
  assign sel_write = reg_wr && !reg_bit_op && hit_select;
  assign read_byte = hit_status ? status :
                     hit_select ? {5'h00, sel_reg} : 8'h00;

  // Select register; status has no write path at all
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      sel_reg <= SELECT_RESET;
    end else if (sel_write) begin
      sel_reg <= reg_wdata[SEL_W-1:0];
    end
  end

  // Read data registered; status bit reads also give the chosen bit alone
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      reg_rdata_reg <= STATUS_RESET;
      reg_rbit_reg <= 1'b0;
    end else if (reg_rd) begin
      reg_rdata_reg <= read_byte;
      reg_rbit_reg <= reg_bit_op && hit_status &&
                      read_byte[reg_bit_sel];
    end
  end

  // Stop state, oscillator gating
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      stop_state_reg <= 1'b0;
      main_osc_enable_reg <= 1'b0;
    end else begin
      if (stop_exec) begin
        stop_state_reg <= 1'b1;
      end else if (stop_release) begin
        stop_state_reg <= 1'b0;
      end
      main_osc_enable_reg <= !main_osc_stop && !stop_state_reg;
    end
  end

  // Wake-up hold while the crystal is the CPU clock
  always_comb begin
    hold_next = hold_reg;
    unique case (hold_reg)
      HOLD_IDLE: begin
        if (stop_release && cpu_on_crystal) begin
          hold_next = HOLD_WAIT;
        end
      end
      HOLD_WAIT: begin
        if (cif.done) begin
          hold_next = HOLD_IDLE;
        end
      end
    endcase
  end

  // Hold state and its registered output
  always_ff @(posedge mclk) begin
    if (!resetn) begin
      hold_reg <= HOLD_IDLE;
      cpu_hold_reg <= 1'b0;
    end else begin
      hold_reg <= hold_next;
      cpu_hold_reg <= (hold_next == HOLD_WAIT);
    end
  end

  stab_counter u_counter (
    .mclk (mclk),
    .resetn (resetn),
    .cif (cif)
  );

  // Checks

  property p_clear_on_stop_bit;
    @(posedge mclk) disable iff (!resetn)
    main_osc_stop [*2] |=> status == 8'h00 && cif.count == '0;
  endproperty
  a_clear_on_stop_bit: assert property (p_clear_on_stop_bit)
    else $error("status not cleared while oscillator stop bit held");

  property p_upper_zero;
    @(posedge mclk) disable iff (!resetn)
    status[7:5] == 3'h0;
  endproperty
  a_upper_zero: assert property (p_upper_zero)
    else $error("status upper bits not zero");

  property p_thermometer;
    @(posedge mclk) disable iff (!resetn)
    status[4:0] inside {5'h00, 5'h10, 5'h18, 5'h1c, 5'h1e, 5'h1f};
  endproperty
  a_thermometer: assert property (p_thermometer)
    else $error("status flags not set in order");

  property p_flag_cause;
    @(posedge mclk) disable iff (!resetn)
    $rose(flag_reg[0]) |-> $past(cif.count[THR_POS[0]]);
  endproperty
  a_flag_cause: assert property (p_flag_cause)
    else $error("shortest flag set without its count bit");

  property p_limit;
    @(posedge mclk) disable iff (!resetn)
    $stable(sel_reg) && $past(cif.count) <= (17'h1 << cif.limit_pos) |->
      cif.count <= (17'h1 << cif.limit_pos);
  endproperty
  a_limit: assert property (p_limit)
    else $error("counter ran past selected wait");

  property p_hold_start;
    @(posedge mclk) disable iff (!resetn)
    hold_reg == HOLD_IDLE && stop_release && cpu_on_crystal |=> cpu_hold_reg;
  endproperty
  a_hold_start: assert property (p_hold_start)
    else $error("no hold after stop release on crystal clock");

  property p_hold_end;
    @(posedge mclk) disable iff (!resetn)
    cpu_hold_reg && cif.done |=> !cpu_hold_reg;
  endproperty
  a_hold_end: assert property (p_hold_end)
    else $error("hold not released after wait elapsed");

  property p_select_reset;
    @(posedge mclk) disable iff (!resetn)
    $rose(resetn) |-> sel_reg == SELECT_RESET;
  endproperty
  a_select_reset: assert property (p_select_reset)
    else $error("select register not five after reset");

  property p_no_bit_write;
    @(posedge mclk) disable iff (!resetn)
    reg_wr && reg_bit_op |=> $stable(sel_reg);
  endproperty
  a_no_bit_write: assert property (p_no_bit_write)
    else $error("bit write changed select register");

  property p_bit_read;
    @(posedge mclk) disable iff (!resetn)
    reg_rd && reg_bit_op && hit_status |=>
      reg_rbit_reg == $past(status[reg_bit_sel]);
  endproperty
  a_bit_read: assert property (p_bit_read)
    else $error("bit read of status returned wrong value");

  property p_osc_gate;
    @(posedge mclk) disable iff (!resetn)
    main_osc_stop |=> !main_osc_enable_reg;
  endproperty
  a_osc_gate: assert property (p_osc_gate)
    else $error("oscillator enabled while stop bit set");

  c_all_flags: cover property (@(posedge mclk) disable iff (!resetn)
    status[4:0] == 5'h1f);
  c_hold_done: cover property (@(posedge mclk) disable iff (!resetn)
    cpu_hold_reg ##1 !cpu_hold_reg);
  c_short_wait: cover property (@(posedge mclk) disable iff (!resetn)
    sel_reg == SEL_2E11 && cif.done);

endmodule

// ---- verif/stabilization_timer_tb.sv ----
// Purpose: Self-checking bench for the crystal stabilization timer.
// Assumes: Crystal is driven by the bench at 8 mclk per period, only
//   while the oscillator is enabled; wait code 1 keeps the run short.
// Notes: Inputs change 1 ns after the rising edge; outputs are read then.

`define CHK(nm, ex, got) \
  begin \
    checks_done++; \
    if ((got) !== (ex)) begin \
      n_errors++; \
      $display("[FAIL] %s expected %h seen %h", nm, ex, got); \
    end \
  end

module stabilization_timer_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import ost_pkg::*;

  // Stimulus and observed signals
  logic mclk;
  logic resetn;
  logic [15:0] reg_addr;
  logic reg_rd;
  logic reg_wr;
  logic reg_bit_op;
  logic [2:0] reg_bit_sel;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata_reg;
  logic reg_rbit_reg;
  logic main_crystal;
  logic main_osc_stop;
  logic stop_exec;
  logic stop_release;
  logic cpu_on_crystal;
  logic main_osc_enable_reg;
  logic cpu_hold_reg;
  int n_errors = 0;
  int checks_done = 0;

  stabilization_timer stabilization_timer_inst (
    .mclk(mclk),
    .resetn(resetn),
    .reg_addr(reg_addr),
    .reg_rd(reg_rd),
    .reg_wr(reg_wr),
    .reg_bit_op(reg_bit_op),
    .reg_bit_sel(reg_bit_sel),
    .reg_wdata(reg_wdata),
    .reg_rdata_reg(reg_rdata_reg),
    .reg_rbit_reg(reg_rbit_reg),
    .main_crystal(main_crystal),
    .main_osc_stop(main_osc_stop),
    .stop_exec(stop_exec),
    .stop_release(stop_release),
    .cpu_on_crystal(cpu_on_crystal),
    .main_osc_enable_reg(main_osc_enable_reg),
    .cpu_hold_reg(cpu_hold_reg)
  );

  // 125 MHz clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // Every drive lands 1 ns after an edge, away from sampling
  task automatic step(int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset();
    resetn = 1'b0;
    step(10);
    resetn = 1'b1;
  endtask

  task automatic wr(logic [15:0] a, logic [7:0] d, logic b);
    reg_addr = a;
    reg_wdata = d;
    reg_bit_op = b;
    reg_wr = 1'b1;
    step(1);
    reg_wr = 1'b0;
    reg_bit_op = 1'b0;
  endtask

  // Read data is registered at the strobe edge, so it is ready on return
  task automatic rd(logic [15:0] a, logic b, logic [2:0] s);
    reg_addr = a;
    reg_bit_op = b;
    reg_bit_sel = s;
    reg_rd = 1'b1;
    step(1);
    reg_rd = 1'b0;
    reg_bit_op = 1'b0;
  endtask

  task automatic chk_reg(string nm, logic [15:0] a, logic [7:0] ex);
    rd(a, 1'b0, 3'h0);
    `CHK(nm, ex, reg_rdata_reg)
  endtask

  // Crystal edges, then time for the synchronizer and flag stage
  task automatic xtal(int n);
    repeat (n) begin
      main_crystal = 1'b1;
      step(4);
      main_crystal = 1'b0;
      step(4);
    end
    step(8);
  endtask

  task automatic t_reset();
    chk_reg("status", STATUS_ADDR, STATUS_RESET);
    chk_reg("select", SELECT_ADDR, {5'h00, SELECT_RESET});
    chk_reg("unmapped", 16'hffa5, 8'h00);
    `CHK("osc_enable", 1'b1, main_osc_enable_reg)
  endtask

  // Read-only status, byte-only select, every legal code
  task automatic t_regs();
    wr(STATUS_ADDR, 8'hff, 1'b0);
    chk_reg("status_ro", STATUS_ADDR, 8'h00);
    wr(SELECT_ADDR, 8'h01, 1'b1);
    chk_reg("select_bitwr", SELECT_ADDR, 8'h05);
    for (int c = 5; c >= 1; c--) begin
      wr(SELECT_ADDR, 8'(c), 1'b0);
      chk_reg("select_code", SELECT_ADDR, 8'(c));
    end
  endtask

  // Exact threshold, bit reads, and halt at the selected wait
  task automatic t_count();
    xtal(2040);
    chk_reg("before_2e11", STATUS_ADDR, 8'h00);
    xtal(8);
    chk_reg("at_2e11", STATUS_ADDR, 8'h10);
    rd(STATUS_ADDR, 1'b1, 3'h4);
    `CHK("bit4", 1'b1, reg_rbit_reg)
    rd(STATUS_ADDR, 1'b1, 3'h3);
    `CHK("bit3", 1'b0, reg_rbit_reg)
    xtal(100);
    chk_reg("halted", STATUS_ADDR, 8'h10);
  endtask

  task automatic t_main_osc_stop();
    main_osc_stop = 1'b1;
    step(2);
    `CHK("osc_off", 1'b0, main_osc_enable_reg)
    chk_reg("main_osc_stop_clr", STATUS_ADDR, 8'h00);
    main_osc_stop = 1'b0;
    step(2);
    `CHK("osc_on", 1'b1, main_osc_enable_reg)
  endtask

  // Stop entry clears, wake on crystal holds the CPU for the wait
  task automatic t_stop();
    xtal(2048);
    // Wait chosen before the stop instruction; crystal clock selected only for the wake
    wr(SELECT_ADDR, {5'h00, SEL_2E11}, 1'b0);
    stop_exec = 1'b1;
    step(1);
    stop_exec = 1'b0;
    step(1);
    chk_reg("stop_clr", STATUS_ADDR, 8'h00);
    `CHK("osc_stopped", 1'b0, main_osc_enable_reg)
    cpu_on_crystal = 1'b1;
    stop_release = 1'b1;
    step(1);
    stop_release = 1'b0;
    step(2);
    `CHK("hold_on", 1'b1, cpu_hold_reg)
    `CHK("osc_wake", 1'b1, main_osc_enable_reg)
    // Select stays untouched while the wait runs
    xtal(2040);
    `CHK("hold_mid", 1'b1, cpu_hold_reg)
    xtal(8);
    `CHK("hold_off", 1'b0, cpu_hold_reg)
    chk_reg("wake_status", STATUS_ADDR, 8'h10);
  endtask

  // Wake on the internal clock never holds the CPU
  task automatic t_refuse();
    // Wait no shorter than the threshold polled below
    wr(SELECT_ADDR, {5'h00, SEL_2E11}, 1'b0);
    cpu_on_crystal = 1'b0;
    stop_exec = 1'b1;
    step(1);
    stop_exec = 1'b0;
    step(2);
    stop_release = 1'b1;
    step(1);
    stop_release = 1'b0;
    step(2);
    `CHK("no_hold", 1'b0, cpu_hold_reg)
    // Software on the internal clock polls status instead
    xtal(2048);
    chk_reg("poll_status", STATUS_ADDR, 8'h10);
  endtask

  task automatic summarize();
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // Main sequence; second reset lands with flags set
  initial begin
    resetn = 1'b0;
    reg_addr = 16'h0000;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    reg_bit_op = 1'b0;
    reg_bit_sel = 3'h0;
    reg_wdata = 8'h00;
    main_crystal = 1'b0;
    main_osc_stop = 1'b0;
    stop_exec = 1'b0;
    stop_release = 1'b0;
    cpu_on_crystal = 1'b0;
    do_reset();
    t_reset();
    t_regs();
    t_count();
    t_main_osc_stop();
    t_stop();
    do_reset();
    t_reset();
    t_refuse();
    summarize();
  end

  // Run needs about 67k cycles; a hang is cut before 100k
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors++;
    summarize();
  end
endmodule
